// ==== logic/wse_pkg.sv ====
// Package of offsets, field layouts and reset values for the wake event block
package wse_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFF_STATUS_SIX = 8'h07;
  localparam logic [7:0] OFF_ENABLE_ONE = 8'h08;
  localparam logic [7:0] OFF_ENABLE_THREE = 8'h09;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0D;
  // Status six field positions
  localparam int STS_LOW_BATTERY = 0;
  localparam int STS_GPIO_60 = 2;
  localparam int STS_GPIO_61 = 3;
  localparam int STS_MOUSE_CLICK = 4;
  localparam int STS_SPECIFIC_KEY = 5;
  localparam int STS_POWER_BUTTON = 6;
  // Implemented bit masks; reserved bits read as zero
  localparam logic [7:0] STATUS_SIX_MASK = 8'h7D;
  localparam logic [7:0] ENABLE_ONE_MASK = 8'h5F;
  localparam logic [7:0] ENABLE_THREE_MASK = 8'h7F;
  localparam logic [1:0] IRQ_MASK_BITS = 2'h3;
  // Reset values
  localparam logic [7:0] STATUS_SIX_RST = 8'h00;
  localparam logic [7:0] STATUS_SIX_LOWBAT = 8'h01;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Interrupt status bit positions
  localparam int IRQ_NEW_EVENT = 0;
  localparam int IRQ_WAKE_RISE = 1;
  // Start-up sequencer states
  typedef enum logic [0:0] {
    WSE_ST_CAPTURE = 1'b0,
    WSE_ST_RUN = 1'b1
  } wse_state_e;
endpackage

// ==== logic/wse_core.sv ====
// Wake event status six, enables one and three, and the open wake output
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module wse_core (
  input wire logic core_clk, // 200 MHz clock
  input wire logic resetn, // Standby power-on reset, async, low
  input wire logic main_por, // Main power-on reset pulse, only sets low battery in status six
  input wire logic batt_lost_standby, // Battery replaced or under 1.2V seen at standby reset
  input wire logic batt_low_main, // Battery under 2.4V seen, sampled at main reset
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe
  input wire logic gpio_60, // Wake event pulse
  input wire logic gpio_61, // Wake event pulse
  input wire logic specific_mouse_click_status, // Mouse click wake event pulse
  input wire logic specific_key_status, // Specific key wake event pulse
  input wire logic power_button_status, // Power button wake event pulse
  input wire logic [7:0] wake_status_one, // Status one, kept elsewhere
  input wire logic [7:0] wake_status_three, // Status three, kept elsewhere
  input wire logic [7:0] wake_enable_six, // Enable six, kept elsewhere
  input wire logic global_wake_enable, // Global wake enable
  output logic wake_output_n_o, // Wake pin drive value, always low
  output logic wake_output_n_oe, // Wake pin enable, high while pulling low
  output logic irq // Level interrupt to local software
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and storage

  wse_pkg::wse_state_e state_r; // Start-up sequencer
  logic [7:0] status_six_r; // Latched status six
  logic [7:0] enable_one_r; // Enable one
  logic [7:0] enable_three_r; // Enable three
  logic [1:0] irq_status_r; // Sticky interrupt causes
  logic [1:0] irq_mask_r; // Interrupt mask, one enables
  logic wake_active_r; // Wake pin pulled low
  logic [7:0] status_six_nxt; // Next status six
  logic [7:0] status_set; // Bits set this cycle
  logic [7:0] status_clr; // Bits cleared this cycle
  logic wake_nxt; // Next wake level
  logic [1:0] irq_set; // Interrupt causes this cycle

  // Address match for a strobe
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] off);
    hit = strobe && (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Start-up capture

  // A level cannot be loaded under async reset, so the standby strap
  // is caught in the first clocked cycle after release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= wse_pkg::WSE_ST_CAPTURE;
    end else begin
      case (state_r)
        wse_pkg::WSE_ST_CAPTURE: begin
          state_r <= wse_pkg::WSE_ST_RUN;
        end
        wse_pkg::WSE_ST_RUN: begin
          state_r <= wse_pkg::WSE_ST_RUN;
        end
        default: begin
          state_r <= wse_pkg::WSE_ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status six

  // Gather set and clear terms; the set side wins over a clear
  always_comb begin
    status_set = 8'h00;
    status_set[wse_pkg::STS_GPIO_60] = gpio_60;
    status_set[wse_pkg::STS_GPIO_61] = gpio_61;
    status_set[wse_pkg::STS_MOUSE_CLICK] = specific_mouse_click_status;
    status_set[wse_pkg::STS_SPECIFIC_KEY] = specific_key_status;
    status_set[wse_pkg::STS_POWER_BUTTON] = power_button_status;
    if (state_r == wse_pkg::WSE_ST_CAPTURE && batt_lost_standby) begin
      status_set = status_set | wse_pkg::STATUS_SIX_LOWBAT;
    end
    if (main_por && batt_low_main) begin
      status_set = status_set | wse_pkg::STATUS_SIX_LOWBAT;
    end
    status_clr = 8'h00;
    if (hit(reg_wr, reg_addr, wse_pkg::OFF_STATUS_SIX)) begin
      status_clr = reg_wdata;
    end
    status_six_nxt = ((status_six_r & ~status_clr) | status_set) & wse_pkg::STATUS_SIX_MASK;
  end

  // only the standby reset clears status six; main reset can only set low battery
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_six_r <= wse_pkg::STATUS_SIX_RST;
    end else begin
      status_six_r <= status_six_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable registers

  // standby reset only; main reset input is not wired here
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enable_one_r <= wse_pkg::ENABLE_RST;
    end else if (hit(reg_wr, reg_addr, wse_pkg::OFF_ENABLE_ONE)) begin
      // reserved bits five and seven dropped
      enable_one_r <= reg_wdata & wse_pkg::ENABLE_ONE_MASK;
    end
  end

  // Enable three, written whole apart from its reserved bit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enable_three_r <= wse_pkg::ENABLE_RST;
    end else if (hit(reg_wr, reg_addr, wse_pkg::OFF_ENABLE_THREE)) begin
      enable_three_r <= reg_wdata & wse_pkg::ENABLE_THREE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake output

  // Low battery only reaches the pin through its own enable six bit,
  // like any other source; it never forms a separate wake path
  always_comb begin
    // OR of gated status, global gate
    // status, enable and global all one
    // low battery gated by its enable
    // no extra wakeup path for it
    wake_nxt = global_wake_enable &&
               (|(status_six_r & wake_enable_six) ||
                |(wake_status_one & enable_one_r) ||
                |(wake_status_three & enable_three_r));
  end

  // Registered so the pin has no glitches from the decode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wake_active_r <= 1'b0;
    end else begin
      wake_active_r <= wake_nxt;
    end
  end

  // Open drain: only ever pull low
  assign wake_output_n_o = 1'b0;
  assign wake_output_n_oe = wake_active_r;

  ////////////////////////////////////////////////////////////////////////////
  // Local interrupt

  // Causes: a new status six bit, and a falling wake pin as the pull-low starts
  always_comb begin
    irq_set = 2'h0;
    irq_set[wse_pkg::IRQ_NEW_EVENT] = |(status_six_nxt & ~status_six_r);
    irq_set[wse_pkg::IRQ_WAKE_RISE] = wake_nxt && !wake_active_r;
  end

  // Read clears, but a cause in the same cycle survives
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_r <= wse_pkg::IRQ_RST;
    end else if (hit(reg_rd, reg_addr, wse_pkg::OFF_IRQ_STATUS)) begin
      irq_status_r <= irq_set;
    end else begin
      irq_status_r <= irq_status_r | irq_set;
    end
  end

  // Mask register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_r <= wse_pkg::IRQ_RST;
    end else if (hit(reg_wr, reg_addr, wse_pkg::OFF_IRQ_MASK)) begin
      irq_mask_r <= reg_wdata[1:0] & wse_pkg::IRQ_MASK_BITS;
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        wse_pkg::OFF_STATUS_SIX: begin
          reg_rdata <= status_six_r;
        end
        wse_pkg::OFF_ENABLE_ONE: begin
          reg_rdata <= enable_one_r;
        end
        wse_pkg::OFF_ENABLE_THREE: begin
          reg_rdata <= enable_three_r;
        end
        wse_pkg::OFF_IRQ_STATUS: begin
          reg_rdata <= {6'h00, irq_status_r};
        end
        wse_pkg::OFF_IRQ_MASK: begin
          reg_rdata <= {6'h00, irq_mask_r};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Event latches whatever the enables say
  a_event_latch: assert property (
    @(posedge core_clk) disable iff (!resetn)
    gpio_60 |=> status_six_r[wse_pkg::STS_GPIO_60])
    else $error("gpio 60 event not latched");

  // Gated status pulls the pin low one cycle later
  a_wake_drive: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (global_wake_enable && |(status_six_r & wake_enable_six)) |=> wake_output_n_oe)
    else $error("wake pin not driven");

  // No global enable means no drive
  a_wake_gated: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !global_wake_enable |=> !wake_output_n_oe)
    else $error("wake driven without global enable");

  // Standby strap sets low battery
  a_lowbat_standby: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (state_r == wse_pkg::WSE_ST_CAPTURE && batt_lost_standby)
      |=> status_six_r[wse_pkg::STS_LOW_BATTERY])
    else $error("standby low battery not set");

  // Main reset with low battery sets bit zero
  a_lowbat_main: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (main_por && batt_low_main) |=> status_six_r[wse_pkg::STS_LOW_BATTERY])
    else $error("main reset low battery not set");

  // A written one clears a bit with no fresh event
  a_w1c_clear: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (hit(reg_wr, reg_addr, wse_pkg::OFF_STATUS_SIX) && reg_wdata[wse_pkg::STS_GPIO_61]
      && !gpio_61) |=> !status_six_r[wse_pkg::STS_GPIO_61])
    else $error("write one did not clear");

  // Reserved status bits never set
  a_rsvd_zero: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (status_six_r & ~wse_pkg::STATUS_SIX_MASK) == 8'h00)
    else $error("reserved status bit set");

  // Enable one holds without a write, main reset included
  a_enable_hold: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !hit(reg_wr, reg_addr, wse_pkg::OFF_ENABLE_ONE) |=> $stable(enable_one_r))
    else $error("enable one changed without write");

  // Reserved enable three bit stays zero after a write
  a_en3_rsvd: assert property (
    @(posedge core_clk) disable iff (!resetn)
    hit(reg_wr, reg_addr, wse_pkg::OFF_ENABLE_THREE) |=> !enable_three_r[7])
    else $error("enable three reserved bit set");

  // Read data show the register one cycle on
  a_read_en1: assert property (
    @(posedge core_clk) disable iff (!resetn)
    hit(reg_rd, reg_addr, wse_pkg::OFF_ENABLE_ONE) |=> reg_rdata == $past(enable_one_r))
    else $error("enable one read mismatch");

  // A written zero leaves a set bit alone
  a_w1c_keep: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (hit(reg_wr, reg_addr, wse_pkg::OFF_STATUS_SIX) && !reg_wdata[wse_pkg::STS_POWER_BUTTON]
      && status_six_r[wse_pkg::STS_POWER_BUTTON]) |=> status_six_r[wse_pkg::STS_POWER_BUTTON])
    else $error("written zero cleared a bit");

  // A source with its enable off still latches
  a_masked_latch: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (power_button_status && !wake_enable_six[wse_pkg::STS_POWER_BUTTON])
      |=> status_six_r[wse_pkg::STS_POWER_BUTTON])
    else $error("disabled source not latched");

  // Main reset never drops a latched status bit
  a_main_keep: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (main_por && !hit(reg_wr, reg_addr, wse_pkg::OFF_STATUS_SIX))
      |=> ((status_six_r & $past(status_six_r)) == $past(status_six_r)))
    else $error("main reset dropped a status bit");

  // Enable three holds without a write, main reset included
  a_en3_hold: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !hit(reg_wr, reg_addr, wse_pkg::OFF_ENABLE_THREE) |=> $stable(enable_three_r))
    else $error("enable three changed without write");

  // Status one reaches the same pin through enable one
  a_wake_other: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (global_wake_enable && |(wake_status_one & enable_one_r)) |=> wake_output_n_oe)
    else $error("status one did not drive wake");

endmodule

// ==== verif/wse_host_model.sv ====
// Host chipset wake input model on the open-drain wake wire
`timescale 1ns/10ps
module wse_host_model (
  input wire logic wake_output_n_o, // Drive value from the device
  input wire logic wake_output_n_oe, // Device pulls the wire while high
  output logic wake_line // Wire level as the chipset sees it
);
  // Board pull-up holds the wire high whenever the device lets go
  assign wake_line = wake_output_n_oe ? wake_output_n_o : 1'b1;
endmodule

// ==== verif/tb_wse_core.sv ====
// Self-checking testbench for the wake event status and enable block
`timescale 1ns/10ps
module tb_wse_core;
  logic core_clk = 1'b0; // 200 MHz clock
  logic resetn = 1'b0; // Standby power-on reset
  logic main_por = 1'b0; // Main power-on reset pulse
  logic batt_lost_standby = 1'b0; // Battery lost at standby reset
  logic batt_low_main = 1'b0; // Battery low at main reset
  logic [7:0] reg_addr = 8'h00; // Register offset
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic reg_wr = 1'b0; // Write strobe
  logic reg_rd = 1'b0; // Read strobe
  logic [4:0] evt = 5'h00; // Five status six sources, bit 0 first
  logic [7:0] sts_one = 8'h00; // Status one from outside
  logic [7:0] sts_three = 8'h00; // Status three from outside
  logic [7:0] en_six = 8'h00; // Enable six from outside
  logic glb = 1'b0; // Global wake enable
  logic [7:0] reg_rdata; // Read data
  logic wake_o; // Wake drive value
  logic wake_oe; // Wake drive enable
  logic wake_line; // Resolved wake wire
  logic irq; // Level interrupt
  logic [7:0] rd_v; // Last read value
  logic [7:0] exp_sts; // Expected status six
  int mismatches = 0; // Mismatch count
  int compares = 0; // Comparison count

  // 5 ns period
  always #2.5 core_clk = ~core_clk;

  wse_core i_dut (.core_clk(core_clk), .resetn(resetn), .main_por(main_por),
    .batt_lost_standby(batt_lost_standby), .batt_low_main(batt_low_main),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gpio_60(evt[0]), .gpio_61(evt[1]),
    .specific_mouse_click_status(evt[2]), .specific_key_status(evt[3]),
    .power_button_status(evt[4]), .wake_status_one(sts_one),
    .wake_status_three(sts_three), .wake_enable_six(en_six),
    .global_wake_enable(glb), .wake_output_n_o(wake_o), .wake_output_n_oe(wake_oe),
    .irq(irq));

  wse_host_model i_host (.wake_output_n_o(wake_o), .wake_output_n_oe(wake_oe),
    .wake_line(wake_line));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
    check(rd_v, exp);
  endtask

  // One-cycle event pulse on chosen sources
  task automatic pulse(input logic [4:0] m);
    @(posedge core_clk);
    evt <= m;
    @(posedge core_clk);
    evt <= 5'h00;
  endtask

  // Drive follows its cause one cycle later; allow that and settle
  task automatic wake_is(input logic e);
    repeat (2) @(posedge core_clk);
    #1 check({7'h00, wake_line}, {7'h00, e});
  endtask

  // Standby reset held two cycles; battery flag kept through capture
  task automatic do_reset(input logic lost);
    @(posedge core_clk);
    resetn <= 1'b0;
    batt_lost_standby <= lost;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    batt_lost_standby <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: the main sequence needs far fewer cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset(1'b0);
    rdc(wse_pkg::OFF_STATUS_SIX, 8'h00);
    rdc(wse_pkg::OFF_ENABLE_ONE, 8'h00);
    rdc(wse_pkg::OFF_ENABLE_THREE, 8'h00);
    wr(wse_pkg::OFF_ENABLE_ONE, 8'hFF);
    rdc(wse_pkg::OFF_ENABLE_ONE, 8'h5F);
    wr(wse_pkg::OFF_ENABLE_THREE, 8'hFF);
    rdc(wse_pkg::OFF_ENABLE_THREE, 8'h7F);
    rdc(8'h20, 8'h00);
    rdc(wse_pkg::OFF_IRQ_STATUS, 8'h00);
    wr(wse_pkg::OFF_IRQ_MASK, 8'h00);
    // Each source alone, global on but enable six all clear
    @(posedge core_clk);
    glb <= 1'b1;
    exp_sts = 8'h00;
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      exp_sts = exp_sts | (8'h04 << i);
      rdc(wse_pkg::OFF_STATUS_SIX, exp_sts);
    end
    wake_is(1'b1);
    // Pending event reaches the interrupt only once unmasked
    #1 check({7'h00, irq}, 8'h00);
    wr(wse_pkg::OFF_IRQ_MASK, 8'h03);
    #1 check({7'h00, irq}, 8'h01);
    rdc(wse_pkg::OFF_IRQ_MASK, 8'h03);
    rdc(wse_pkg::OFF_IRQ_STATUS, 8'h01);
    #1 check({7'h00, irq}, 8'h00);
    // Enabled source pulls the wire; global enable gates it
    @(posedge core_clk);
    en_six <= 8'h04;
    wake_is(1'b0);
    rdc(wse_pkg::OFF_IRQ_STATUS, 8'h02);
    @(posedge core_clk);
    glb <= 1'b0;
    wake_is(1'b1);
    @(posedge core_clk);
    glb <= 1'b1;
    wr(wse_pkg::OFF_STATUS_SIX, 8'h0C);
    rdc(wse_pkg::OFF_STATUS_SIX, 8'h70);
    wake_is(1'b1);
    wr(wse_pkg::OFF_STATUS_SIX, 8'h00);
    rdc(wse_pkg::OFF_STATUS_SIX, 8'h70);
    // Main reset flags low battery and keeps everything else
    @(posedge core_clk);
    main_por <= 1'b1;
    batt_low_main <= 1'b1;
    @(posedge core_clk);
    main_por <= 1'b0;
    batt_low_main <= 1'b0;
    rdc(wse_pkg::OFF_STATUS_SIX, 8'h71);
    rdc(wse_pkg::OFF_ENABLE_ONE, 8'h5F);
    wake_is(1'b1);
    @(posedge core_clk);
    en_six <= 8'h01;
    wake_is(1'b0);
    // Other status registers join the same wake wire
    @(posedge core_clk);
    en_six <= 8'h00;
    sts_one <= 8'h01;
    wake_is(1'b0);
    @(posedge core_clk);
    sts_one <= 8'h00;
    sts_three <= 8'h40;
    wake_is(1'b0);
    @(posedge core_clk);
    sts_three <= 8'h00;
    wake_is(1'b1);
    // Standby reset with the battery lost
    do_reset(1'b1);
    rdc(wse_pkg::OFF_STATUS_SIX, 8'h01);
    rdc(wse_pkg::OFF_ENABLE_THREE, 8'h00);
    summarize();
  end
endmodule
